//--- logic/led_port_pkg.sv
// Purpose: constants for the led driver serial host port
// Assumes: 200 MHz core clock
// Notes: bus slave address, section select and shutdown encodings
package led_port_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned ADDR_SETTLE_MS = 5;
    localparam int unsigned ADDR_SETTLE_CYC = CLK_HZ / 1000 * ADDR_SETTLE_MS;
    localparam logic [3:0] FIXED_ADDR_HIGH = 4'h6;
    localparam logic [6:0] BROADCAST_ADDR = 7'h3F;
    localparam logic [7:0] SECTION_SELECT_CMD = 8'hFD;
    localparam logic [7:0] SECTION_DEFAULT = 8'hC0;
    localparam logic [7:0] CONFIG_REG_ADDR = 8'h06;
    localparam int unsigned CFG_BROADCAST_BIT = 6;
    localparam logic [7:0] SHUTDOWN_REG_ADDR = 8'h09;
    localparam int unsigned SHDN_BIT = 0;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] SHUTDOWN_RESET = 8'h00;
endpackage

//--- logic/pin_sync.sv
// Purpose: three stage synchroniser with agreement filter
// Assumes: input asynchronous to clk_i
// Notes: output changes once stages two and three agree
`timescale 1ns/1ps
module pin_sync
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic level_o
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic next_level;

    always_comb
    begin
        next_stage = {stage[1:0], pin_i};
        next_level = (stage[2] == stage[1]) ? stage[1] : level_o;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stage <= 3'h7;
            level_o <= 1'b1;
        end
        else
        begin
            stage <= next_stage;
            level_o <= next_level;
        end
    end
endmodule

//--- logic/led_driver_i2c_slave_port.sv
// Purpose: two wire target port of an led matrix driver
// Assumes: master owns clock and conditions; one 200 MHz clock
// Notes: second byte of a write is a command address, then data
//
// How it works
// RULE_01 - device is target only; lines sampled fast enough for 1 MHz.
// RULE_02 - master makes clock, START and STOP; clock pin never driven.
// RULE_03 - data edges during clock high are taken as conditions.
// RULE_04 - data falling with clock high starts a transfer.
// RULE_05 - data rising with clock high ends the transfer.
// RULE_06 - master starts only on idle bus, both lines high.
// RULE_07 - eight bits per byte, then a ninth acknowledge bit.
// RULE_08 - acknowledger holds data low across the ninth clock high.
// RULE_09 - on master no-ack during read, device releases data.
// RULE_10 - any byte count between START and STOP accepted.
// RULE_11 - in writes, address and every data byte acknowledged.
// RULE_12 - repeated START begins the next transfer at once.
// RULE_13 - first byte is address; bits 3 to 1 from select pin.
// RULE_14 - address bit 0 set means read, clear means write.
// RULE_15 - broadcast address 0111111 answered when enabled in config.
// RULE_16 - select code follows strap resistance code 000 to 111.
// RULE_17 - select sampled once after reset, held until next reset.
// RULE_18 - address settles 5 ms after power-up before answering.
// RULE_19 - at power-up registers default, display blank, shutdown.
// RULE_20 - host sets layout, control, then shutdown bit to one.
// RULE_21 - software shutdown turns leds off and halts logic.
// RULE_22 - reset pin low powers down power-on reset and halts.
// RULE_23 - writing command 0xFD selects section for later commands.
// RULE_24 - unmatched address left unacknowledged, data released.
`timescale 1ns/1ps
module led_driver_i2c_slave_port
    import led_port_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = ADDR_SETTLE_CYC
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic active_low_reset_pin_i,
    input wire logic select_bit_high_i,
    input wire logic select_bit_mid_i,
    input wire logic select_bit_low_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [7:0] read_data_i,
    output logic [7:0] section_o,
    output logic [7:0] cmd_addr_o,
    output logic [7:0] wr_data_o,
    output logic wr_strobe_o,
    output logic rd_strobe_o,
    output logic leds_enable_o,
    output logic logic_run_o,
    output logic por_enable_o,
    output logic addr_ready_o,
    output logic [2:0] strap_addr_o
);
    // =========================================================
    // input synchronisers
    logic scl_s, sda_s, active_low_reset_pin_s;
    pin_sync u_scl (.clk_i(clk_i), .rst_i(rst_i), .pin_i(scl_i), .level_o(scl_s)); // see RULE_01
    pin_sync u_sda (.clk_i(clk_i), .rst_i(rst_i), .pin_i(sda_i), .level_o(sda_s));
    pin_sync u_active_low_reset_pin (.clk_i(clk_i), .rst_i(rst_i), .pin_i(active_low_reset_pin_i),
        .level_o(active_low_reset_pin_s));
    // =========================================================
    // bus condition detection
    logic scl_d, sda_d, start_det, stop_det, scl_rise, scl_fall, hw_rst;
    assign hw_rst = rst_i | ~active_low_reset_pin_s;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s; // see RULE_03 see RULE_04
    assign stop_det = scl_s & scl_d & ~sda_d & sda_s; // see RULE_03 see RULE_05
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end
    // =========================================================
    // strap capture and settle timer
    logic [2:0] strap, next_strap;
    logic [31:0] settle_cnt, next_settle_cnt;
    logic strap_taken, settled, next_strap_taken, next_settled;
    always_comb
    begin
        next_strap = strap;
        next_strap_taken = 1'b1;
        next_settle_cnt = settle_cnt;
        next_settled = settled;
        if (!strap_taken) // see RULE_16 see RULE_17
            next_strap = {select_bit_high_i, select_bit_mid_i, select_bit_low_i};
        if (!settled)
        begin
            next_settle_cnt = settle_cnt + 32'h0000_0001;
            next_settled = (settle_cnt >= SETTLE_CYCLES - 1); // see RULE_18
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (hw_rst)
        begin
            strap <= 3'h0;
            strap_taken <= 1'b0;
            settle_cnt <= 32'h0000_0000;
            settled <= 1'b0;
        end
        else
        begin
            strap <= next_strap;
            strap_taken <= next_strap_taken;
            settle_cnt <= next_settle_cnt;
            settled <= next_settled;
        end
    end
    // =========================================================
    // byte engine
    typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_ADDR = 3'b001, ST_ACK = 3'b011,
        ST_RX = 3'b010, ST_TX = 3'b110, ST_RACK = 3'b111, ST_IGNORE = 3'b101} state_e;
    state_e state, next_state;
    logic [7:0] shreg, next_shreg, next_section, next_cmd_addr, next_wr_data;
    logic [7:0] config_reg, next_config, shutdown_reg, next_shutdown;
    logic [3:0] bitcnt, next_bitcnt;
    logic reading, next_reading, have_cmd, next_have_cmd, next_sda_oe;
    logic next_wr_strobe, next_rd_strobe, addr_match;
    // see RULE_13 see RULE_15 see RULE_24
    assign addr_match = settled & ((shreg[7:1] == {FIXED_ADDR_HIGH, strap})
        | (config_reg[CFG_BROADCAST_BIT] & (shreg[7:1] == BROADCAST_ADDR)));
    always_comb
    begin
        next_state = state;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_reading = reading;
        next_have_cmd = have_cmd;
        next_sda_oe = sda_oe_o;
        next_section = section_o;
        next_cmd_addr = cmd_addr_o;
        next_wr_data = wr_data_o;
        next_wr_strobe = 1'b0;
        next_rd_strobe = 1'b0;
        next_config = config_reg;
        next_shutdown = shutdown_reg;
        if (start_det) // see RULE_12
        begin
            next_state = ST_ADDR;
            next_bitcnt = 4'h0;
            next_have_cmd = 1'b0;
            next_sda_oe = 1'b0;
        end
        else if (stop_det)
        begin
            next_state = ST_IDLE;
            next_sda_oe = 1'b0;
        end
        else
        begin
            unique case (state)
                ST_IDLE, ST_IGNORE:
                    next_sda_oe = 1'b0;
                ST_ADDR, ST_RX:
                begin
                    if (scl_rise)
                    begin
                        next_shreg = {shreg[6:0], sda_s}; // see RULE_07
                        next_bitcnt = bitcnt + 4'h1;
                    end
                    else if (scl_fall && bitcnt == 4'h8)
                    begin
                        next_bitcnt = 4'h0;
                        if (state == ST_ADDR)
                        begin
                            if (addr_match)
                            begin
                                next_reading = shreg[0]; // see RULE_14
                                next_sda_oe = 1'b1; // see RULE_08 see RULE_11
                                next_state = ST_ACK;
                            end
                            else
                                next_state = ST_IGNORE; // see RULE_24
                        end
                        else
                        begin
                            next_sda_oe = 1'b1; // see RULE_11
                            next_state = ST_ACK;
                            if (!have_cmd)
                            begin
                                next_have_cmd = 1'b1;
                                next_cmd_addr = shreg;
                            end
                            else if (cmd_addr_o == SECTION_SELECT_CMD)
                                next_section = shreg; // see RULE_23
                            else
                            begin
                                next_wr_data = shreg;
                                next_wr_strobe = 1'b1;
                                if (section_o == SECTION_DEFAULT)
                                begin
                                    if (cmd_addr_o == CONFIG_REG_ADDR)
                                        next_config = shreg;
                                    if (cmd_addr_o == SHUTDOWN_REG_ADDR)
                                        next_shutdown = shreg;
                                end
                                next_cmd_addr = cmd_addr_o + 8'h01;
                            end
                        end
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall && reading)
                    begin
                        next_shreg = read_data_i;
                        next_rd_strobe = 1'b1;
                        next_sda_oe = ~read_data_i[7];
                        next_bitcnt = 4'h1;
                        next_state = ST_TX;
                    end
                    else if (scl_fall)
                    begin
                        next_sda_oe = 1'b0;
                        next_state = ST_RX; // see RULE_10
                    end
                end
                ST_TX:
                begin
                    if (scl_fall && bitcnt == 4'h8)
                    begin
                        next_sda_oe = 1'b0;
                        next_state = ST_RACK;
                    end
                    else if (scl_fall)
                    begin
                        next_sda_oe = ~shreg[3'(7 - bitcnt)];
                        next_bitcnt = bitcnt + 4'h1;
                    end
                end
                ST_RACK:
                begin
                    if (scl_rise)
                    begin
                        next_state = sda_s ? ST_IGNORE : ST_ACK; // no-ack releases, see RULE_09
                        next_cmd_addr = cmd_addr_o + 8'h01;
                    end
                end
                default:
                    next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (hw_rst) // see RULE_19
        begin
            state <= ST_IDLE;
            shreg <= 8'h00;
            bitcnt <= 4'h0;
            reading <= 1'b0;
            have_cmd <= 1'b0;
            sda_oe_o <= 1'b0;
            section_o <= SECTION_DEFAULT;
            cmd_addr_o <= 8'h00;
            wr_data_o <= 8'h00;
            wr_strobe_o <= 1'b0;
            rd_strobe_o <= 1'b0;
            config_reg <= CONFIG_RESET;
            shutdown_reg <= SHUTDOWN_RESET;
        end
        else
        begin
            state <= next_state;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            reading <= next_reading;
            have_cmd <= next_have_cmd;
            sda_oe_o <= next_sda_oe;
            section_o <= next_section;
            cmd_addr_o <= next_cmd_addr;
            wr_data_o <= next_wr_data;
            wr_strobe_o <= next_wr_strobe;
            rd_strobe_o <= next_rd_strobe;
            config_reg <= next_config;
            shutdown_reg <= next_shutdown;
        end
    end
    // =========================================================
    // shutdown and status outputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sda_o <= 1'b0;
            leds_enable_o <= 1'b0;
            logic_run_o <= 1'b0;
            por_enable_o <= 1'b1;
            addr_ready_o <= 1'b0;
            strap_addr_o <= 3'h0;
        end
        else
        begin
            sda_o <= 1'b0; // open drain: only ever pulls low
            leds_enable_o <= active_low_reset_pin_s & shutdown_reg[SHDN_BIT]; // see RULE_21
            logic_run_o <= active_low_reset_pin_s & shutdown_reg[SHDN_BIT]; // see RULE_21 see RULE_22
            por_enable_o <= active_low_reset_pin_s; // see RULE_22
            addr_ready_o <= settled;
            strap_addr_o <= strap;
        end
    end
    // =========================================================
    // checks
    a_start_enters_addr: assert property (@(posedge clk_i) disable iff (hw_rst) // see RULE_04
        start_det |=> state == ST_ADDR) else $error("start not taken");
    a_stop_goes_idle: assert property (@(posedge clk_i) disable iff (hw_rst) // see RULE_05
        stop_det && !start_det |=> state == ST_IDLE && !sda_oe_o) else $error("stop not taken");
    a_no_ack_unsettled: assert property (@(posedge clk_i) disable iff (hw_rst) // see RULE_18
        !settled && state == ST_ADDR |=> state != ST_ACK) else $error("ack while unsettled");
    a_ignore_released: assert property (@(posedge clk_i) disable iff (hw_rst) // see RULE_24
        state == ST_IGNORE && !start_det |=> !sda_oe_o) else $error("driving while ignored");
    a_nack_releases: assert property (@(posedge clk_i) disable iff (hw_rst) // see RULE_09
        state == ST_RACK && scl_rise && sda_s && !start_det && !stop_det
        |=> state == ST_IGNORE && !sda_oe_o) else $error("no release after master nack");
    a_ack_held_high: assert property (@(posedge clk_i) disable iff (hw_rst) // see RULE_08
        state == ST_ACK && sda_oe_o && scl_s && !start_det && !stop_det |=> sda_oe_o)
        else $error("ack dropped during clock high");
    a_section_select: assert property (@(posedge clk_i) disable iff (hw_rst) // see RULE_23
        state == ST_RX && scl_fall && bitcnt == 4'h8 && have_cmd
        && cmd_addr_o == SECTION_SELECT_CMD && !start_det && !stop_det
        |=> section_o == $past(shreg)) else $error("section not selected");
    a_shdn_leds_off: assert property (@(posedge clk_i) disable iff (hw_rst) // see RULE_21
        !shutdown_reg[SHDN_BIT] |=> !leds_enable_o) else $error("leds lit in shutdown");
endmodule

//--- verif/bus_master_model.sv
// Purpose: behavioural two wire bus master for the port bench
// Assumes: open drain lines with pull-ups, resolved in the bench
// Notes: a bit is four quarters of 50 clocks, about 1 MHz
`timescale 1ns/1ps
module bus_master_model
(
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    // ==========
    // timing
    localparam int QTR = 50;

    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic wait_q();
        repeat (QTR) @(posedge clk_i);
        #1;
    endtask

    // ==========
    // conditions and bits
    task automatic start();
        sda_o = 1'b1;
        wait_q();
        scl_o = 1'b1;
        wait_q();
        sda_o = 1'b0;
        wait_q();
        scl_o = 1'b0;
        wait_q();
    endtask

    task automatic stop();
        sda_o = 1'b0;
        wait_q();
        scl_o = 1'b1;
        wait_q();
        sda_o = 1'b1;
        wait_q();
    endtask

    // data moves only while scl is low
    task automatic put_bit(input logic b, output logic r);
        sda_o = b;
        wait_q();
        scl_o = 1'b1;
        wait_q();
        r = sda_i;
        wait_q();
        scl_o = 1'b0;
        wait_q();
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            put_bit(d[i], r);
        end
        put_bit(1'b1, r);
        ack = ~r;
    endtask

    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            put_bit(1'b1, r);
            d[i] = r;
        end
        put_bit(~ack, r);
    endtask
endmodule

//--- verif/led_driver_i2c_slave_port_tb.sv
// Purpose: self-checking bench for the led driver serial host port
// Assumes: bus master model owns scl and its half of sda
// Notes: settle time shortened to 20 cycles
`timescale 1ns/1ps
module led_driver_i2c_slave_port_tb;
    import led_port_pkg::*;
    // ==========
    // signals
    localparam int SETTLE = 20;
    localparam int LIMIT = 90000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reset_pin_n = 1'b1;
    logic [2:0] strap = 3'h5;
    logic [7:0] rd_data = 8'h00;
    logic m_scl, m_sda, sda_line, sda_o, sda_oe, wr_strobe, rd_strobe;
    logic leds_en, run, por_en, ready;
    logic [7:0] section, cmd_addr, wr_data;
    logic [2:0] strap_out;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    int wr_count = 0;
    int rd_count = 0;

    always #2.5 clk = ~clk;
    assign sda_line = m_sda & (sda_oe ? sda_o : 1'b1);

    led_driver_i2c_slave_port #(.SETTLE_CYCLES(SETTLE)) i_dut (.clk_i(clk), .rst_i(rst),
        .active_low_reset_pin_i(reset_pin_n), .select_bit_high_i(strap[2]),
        .select_bit_mid_i(strap[1]), .select_bit_low_i(strap[0]), .scl_i(m_scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe), .read_data_i(rd_data),
        .section_o(section), .cmd_addr_o(cmd_addr), .wr_data_o(wr_data),
        .wr_strobe_o(wr_strobe), .rd_strobe_o(rd_strobe), .leds_enable_o(leds_en),
        .logic_run_o(run), .por_enable_o(por_en), .addr_ready_o(ready),
        .strap_addr_o(strap_out));

    bus_master_model i_master (.clk_i(clk), .sda_i(sda_line), .scl_o(m_scl), .sda_o(m_sda));

    // ==========
    // helpers
    function automatic logic [7:0] dev(input logic [2:0] s, input logic rd);
        return {FIXED_ADDR_HIGH, s, rd};
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wait_ready(output int n);
        n = 0;
        while (ready !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic probe(input logic [7:0] a, input logic exp_ack);
        logic ack;
        i_master.start();
        i_master.send_byte(a, ack);
        chk({7'h00, ack}, {7'h00, exp_ack});
        i_master.stop();
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d);
        logic ack;
        i_master.start();
        i_master.send_byte(a, ack);
        chk({7'h00, ack}, 8'h01);
        i_master.send_byte(c, ack);
        chk({7'h00, ack}, 8'h01);
        i_master.send_byte(d, ack);
        chk({7'h00, ack}, 8'h01);
        i_master.stop();
    endtask

    // ==========
    // scenarios
    task automatic t_reset();
        int n;
        chk(section, SECTION_DEFAULT);
        chk({4'h0, leds_en, run, por_en, ready}, 8'h02);
        wait_ready(n);
        chk({7'h00, ready}, 8'h01);
        chk({5'h00, strap_out}, 8'h05);
        chk({7'h00, n >= SETTLE}, 8'h01);
        $display("test reset done");
    endtask

    task automatic t_section();
        wr_reg(dev(3'h5, 1'b0), SECTION_SELECT_CMD, 8'h80);
        chk(section, 8'h80);
        wr_reg(dev(3'h5, 1'b0), SECTION_SELECT_CMD, SECTION_DEFAULT);
        chk(section, SECTION_DEFAULT);
        $display("test section done");
    endtask

    task automatic t_burst();
        logic ack;
        int w0;
        w0 = wr_count;
        i_master.start();
        i_master.send_byte(dev(3'h5, 1'b0), ack);
        i_master.send_byte(8'h20, ack);
        i_master.send_byte(8'hA5, ack);
        i_master.send_byte(8'h5A, ack);
        i_master.send_byte(8'h3C, ack);
        chk({7'h00, ack}, 8'h01);
        i_master.stop();
        chk(8'(wr_count - w0), 8'h03);
        chk(wr_data, 8'h3C);
        chk(cmd_addr, 8'h23);
        $display("test burst done");
    endtask

    task automatic t_bcast_shutdown();
        logic ack;
        probe(dev(3'h4, 1'b0), 1'b0);
        probe({BROADCAST_ADDR, 1'b0}, 1'b0);
        wr_reg(dev(3'h5, 1'b0), CONFIG_REG_ADDR, 8'h01 << CFG_BROADCAST_BIT);
        i_master.start();
        i_master.send_byte({BROADCAST_ADDR, 1'b0}, ack);
        chk({7'h00, ack}, 8'h01);
        i_master.send_byte(SHUTDOWN_REG_ADDR, ack);
        i_master.send_byte(8'h01 << SHDN_BIT, ack);
        i_master.stop();
        chk({6'h00, leds_en, run}, 8'h03);
        wr_reg(dev(3'h5, 1'b0), SHUTDOWN_REG_ADDR, 8'h00);
        chk({6'h00, leds_en, run}, 8'h00);
        $display("test broadcast and shutdown done");
    endtask

    task automatic t_read();
        logic ack;
        logic [7:0] d;
        int r0;
        r0 = rd_count;
        i_master.start();
        i_master.send_byte(dev(3'h5, 1'b0), ack);
        i_master.send_byte(8'h10, ack);
        rd_data = 8'hA5;
        i_master.start();
        i_master.send_byte(dev(3'h5, 1'b1), ack);
        chk({7'h00, ack}, 8'h01);
        rd_data = 8'h3C;
        i_master.recv_byte(1'b1, d);
        chk(d, 8'hA5);
        i_master.recv_byte(1'b0, d);
        chk(d, 8'h3C);
        chk({7'h00, sda_oe}, 8'h00);
        i_master.stop();
        chk(8'(rd_count - r0), 8'h02);
        $display("test read done");
    endtask

    task automatic t_pin_reset();
        int n;
        reset_pin_n = 1'b0;
        strap = 3'h2;
        repeat (20) @(posedge clk);
        #1;
        chk({6'h00, por_en, run}, 8'h00);
        reset_pin_n = 1'b1;
        wait_ready(n);
        strap = 3'h7;
        repeat (10) @(posedge clk);
        #1;
        chk({5'h00, strap_out}, 8'h02);
        chk(section, SECTION_DEFAULT);
        probe({BROADCAST_ADDR, 1'b0}, 1'b0);
        probe(dev(3'h7, 1'b0), 1'b0);
        wr_reg(dev(3'h2, 1'b0), SECTION_SELECT_CMD, 8'h41);
        chk(section, 8'h41);
        $display("test pin reset done");
    endtask

    // ==========
    // run control
    always @(posedge clk)
    begin
        cycles++;
        if (wr_strobe === 1'b1)
            wr_count++;
        if (rd_strobe === 1'b1)
            rd_count++;
        if (cycles == LIMIT)
        begin
            failures++;
            end_sim();
        end
    end

    initial
    begin
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_section();
        t_burst();
        t_bcast_shutdown();
        t_read();
        t_pin_reset();
        end_sim();
    end
endmodule
